/* sbc_pkg.sv */
/*
  Shared constants and types of the LIN basis-chip control logic: register
  map, field positions, reset values, timing counts and the mode encoding.
  Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register port.
*/
`default_nettype none
package sbc_pkg;
  localparam int unsigned CLK_MHZ = 100;
  // Times in microseconds as printed, cycle counts derived from them
  localparam int unsigned LEAD_TIME_US    = 155_000;
  localparam int unsigned DOM_TIMEOUT_US  = 6_000;
  localparam int unsigned DOM_SLEEP_US    = 20_000;
  localparam int unsigned LEAD_CYCLES     = LEAD_TIME_US * CLK_MHZ;
  localparam int unsigned DOM_CYCLES      = DOM_TIMEOUT_US * CLK_MHZ + 1;
  localparam int unsigned DOM_SLEEP_CYC   = DOM_SLEEP_US * CLK_MHZ + 1;
  // Watchdog intervals in oscillator periods
  localparam int unsigned WDT_CLOSED_OSC  = 16;
  localparam int unsigned WDT_OPEN_OSC    = 16;
  localparam int unsigned WDT_RESET_OSC   = 4;
  localparam int unsigned WDT_OSC_CYC_RST = 100;

  // Register byte addresses
  localparam logic [7:0] CTRL_OFFS   = 8'h00;
  localparam logic [7:0] STATUS_OFFS = 8'h04;
  localparam logic [7:0] OSC_OFFS    = 8'h08;
  // Control fields
  localparam int unsigned CTRL_SLEEP_BIT  = 0;
  localparam int unsigned CTRL_SILENT_BIT = 1;
  localparam logic [1:0]  CTRL_RESET      = 2'h0;

  typedef enum logic [3:0] {
    MODE_FAILSAFE = 4'b0001,
    MODE_NORMAL   = 4'b0010,
    MODE_SILENT   = 4'b0100,
    MODE_SLEEP    = 4'b1000
  } sbc_mode_t;

  typedef enum logic [2:0] {
    WDT_LEAD   = 3'b001,
    WDT_CLOSED = 3'b010,
    WDT_OPEN   = 3'b100
  } wdt_state_t;

  typedef struct packed {
    logic       local_wake;
    logic       wake_seen;
    logic       dom_timeout;
    logic       wdt_fail;
    logic [3:0] mode;
  } sbc_status_t;
endpackage : sbc_pkg
`default_nettype wire

/* sbc_osc_tick.sv */
/*
  Watchdog oscillator model: a divider whose period in system cycles is set
  by software, standing in for the resistor-set oscillator.
  Assumes a period of at least two cycles.
*/
`default_nettype none
module sbc_osc_tick
  import sbc_pkg::*;
#(
  parameter int unsigned WIDTH = 16
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             ce,
  input  wire logic             run,
  input  wire logic [WIDTH-1:0] period,
  output logic                  tick
);
  if (WIDTH < 2) begin : g_bad_width
    $error("osc width too small");
  end
  logic [WIDTH-1:0] count;
  wire              wrap = (count >= period - 1'b1);
  assign tick = run & wrap;

  // Window and reset intervals scale with this period; the lead time is counted in system cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) count <= '0;
    else if (ce) count <= (!run || wrap) ? '0 : count + 1'b1;
  end
endmodule : sbc_osc_tick
`default_nettype wire

/* sbc_axil_slave.sv */
/*
  AXI4-Lite slave for the three control registers. One write and one read
  at a time; write address and data taken in either order.
  Assumes the master holds payloads until taken.
*/
`default_nettype none
module sbc_axil_slave
  import sbc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [31:0] status_word,
  input  wire logic [15:0] osc_reset_val,
  output logic [1:0]       ctrl,
  output logic [15:0]      osc_period
);
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        osc_loaded;

  assign s_axi_awready = ce & ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ce & ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ce & ~s_axi_rvalid;

  wire       aw_now  = aw_held | s_axi_awvalid;
  wire [7:0] aw_cur  = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wd_cur = w_held ? w_data : s_axi_wdata;
  wire [3:0] ws_cur  = w_held ? w_strb : s_axi_wstrb;
  wire       do_wr   = ce & ~s_axi_bvalid & aw_now & (w_held | s_axi_wvalid);
  wire       wr_ctrl = (aw_cur == CTRL_OFFS);
  wire       wr_osc  = (aw_cur == OSC_OFFS);
  wire       wr_hit  = wr_ctrl | wr_osc | (aw_cur == STATUS_OFFS);
  wire       rd_ctrl = (s_axi_araddr == CTRL_OFFS);
  wire       rd_stat = (s_axi_araddr == STATUS_OFFS);
  wire       rd_osc  = (s_axi_araddr == OSC_OFFS);
  wire [31:0] rd_word = rd_ctrl ? {30'h0, ctrl}
                      : rd_stat ? status_word
                      : rd_osc  ? {16'h0, osc_period} : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      ctrl <= CTRL_RESET;
      osc_period <= 16'h0000;
      osc_loaded <= 1'b0;
    end else if (ce) begin
      // Oscillator period taken from the strap after release
      if (!osc_loaded) begin
        osc_period <= osc_reset_val;
        osc_loaded <= 1'b1;
      end
      if (do_wr) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? 2'h0 : 2'h2;
        if (wr_ctrl && ws_cur[0]) ctrl <= wd_cur[1:0];
        if (wr_osc && ws_cur[0]) osc_period[7:0] <= wd_cur[7:0];
        if (wr_osc && ws_cur[1]) osc_period[15:8] <= wd_cur[15:8];
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_held <= 1'b1;
          aw_addr <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_held <= 1'b1;
          w_data <= s_axi_wdata;
          w_strb <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= (rd_ctrl | rd_stat | rd_osc) ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : sbc_axil_slave
`default_nettype wire

/* lin_sbc_watchdog_mode_control.sv */
/*
  Digital control of a LIN basis chip: mode controller, window watchdog,
  transmit dominant timeout, receive gating, wake handling and the
  auxiliary supply switch. Pins are synchronous to aclk; the reset output
  and the transmit pin are open-drain style with output enables.
*/
`default_nettype none
module lin_sbc_watchdog_mode_control
  import sbc_pkg::*;
#(
  parameter int unsigned LEAD_CYC   = LEAD_CYCLES,
  parameter int unsigned DOM_CYC    = DOM_CYCLES,
  parameter int unsigned DOM_SL_CYC = DOM_SLEEP_CYC,
  parameter int unsigned CNT_W      = 25
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic        wdt_trigger_in_n,
  input  wire logic        ctrl_enable_pin,
  input  wire logic        tx_in,
  output logic             tx_out,
  output logic             tx_oe_n,
  output logic             ctrl_rx_pin,
  output logic             reset_out_n,
  output logic             reset_oe_n,
  output logic             aux_supply_switch_out,
  output logic             bus_drive_dominant,
  input  wire logic        bus_level,
  input  wire logic        local_wake_in_n,
  input  wire logic        ignition_wake_in,
  input  wire logic        bus_wake,
  input  wire logic        undervoltage,
  input  wire logic        watchdog_off_sel,
  input  wire logic [15:0] wdt_oscillator_set,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  if ((LEAD_CYC >= 2**CNT_W) || (DOM_SL_CYC >= 2**CNT_W) || (DOM_CYC < 1)
      || (LEAD_CYC < 1) || (DOM_CYC >= DOM_SL_CYC)) begin : g_bad_timing
    $error("bad timing parameters");
  end

  sbc_mode_t   mode;
  sbc_mode_t   next_mode;
  wdt_state_t  wdt_st;
  sbc_status_t status;
  logic [1:0]  ctrl;
  logic [15:0] osc_period;
  logic        osc_tick;
  logic [CNT_W-1:0] lead_cnt;
  logic [7:0]  win_cnt;
  logic [7:0]  rst_cnt;
  logic        trig_d;
  logic        ign_d;
  logic [CNT_W-1:0] dom_cnt;
  logic        wdt_fail;
  logic        local_wake;
  logic        wake_seen;

  sbc_axil_slave u_regs (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .ce            (ce),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .status_word   ({24'h00_0000, status}),
    .osc_reset_val (wdt_oscillator_set),
    .ctrl          (ctrl),
    .osc_period    (osc_period)
  );

  // Watchdog runs only in Normal and Fail-safe with mode-select low
  wire wdt_run  = ((mode == MODE_NORMAL) || (mode == MODE_FAILSAFE))
                  && !watchdog_off_sel;
  wire in_reset = (rst_cnt != 8'h00);

  sbc_osc_tick #(.WIDTH(16)) u_osc (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    // Keeps ticking through reset, else the reset time never ends
    .run     (wdt_run),
    .period  (osc_period),
    .tick    (osc_tick)
  );

  wire trig_fall   = trig_d && !wdt_trigger_in_n;
  wire good_trig   = wdt_run && (wdt_st == WDT_OPEN) && trig_fall;
  wire early_trig  = wdt_run && (wdt_st == WDT_CLOSED) && trig_fall;
  wire window_end  = osc_tick && (win_cnt == 8'(WDT_OPEN_OSC - 1));
  wire missed      = wdt_run && (wdt_st == WDT_OPEN) && window_end && !trig_fall;
  wire fail_now    = !in_reset && (early_trig || missed);
  wire lead_done   = (lead_cnt == '0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdt_st <= WDT_LEAD;
      lead_cnt <= CNT_W'(LEAD_CYC - 1);
      win_cnt <= 8'h00;
      rst_cnt <= 8'h00;
      trig_d <= 1'b1;
      wdt_fail <= 1'b0;
    end else if (ce) begin
      trig_d <= wdt_trigger_in_n;
      wdt_fail <= fail_now;
      if (!wdt_run) begin
        wdt_st <= WDT_LEAD;
        lead_cnt <= CNT_W'(LEAD_CYC - 1);
        win_cnt <= 8'h00;
        rst_cnt <= 8'h00;
      end else if (fail_now) begin
        rst_cnt <= 8'(WDT_RESET_OSC);
        wdt_st <= WDT_LEAD;
        lead_cnt <= CNT_W'(LEAD_CYC - 1);
        win_cnt <= 8'h00;
      end else if (in_reset) begin
        if (osc_tick || osc_period < 16'h0002) rst_cnt <= rst_cnt - 8'h01;
      end else begin
        case (wdt_st)
          WDT_LEAD: begin
            if (lead_done) wdt_st <= WDT_OPEN;
            else lead_cnt <= lead_cnt - 1'b1;
          end
          WDT_CLOSED: begin
            if (osc_tick) begin
              if (win_cnt == 8'(WDT_CLOSED_OSC - 1)) begin
                wdt_st <= WDT_OPEN;
                win_cnt <= 8'h00;
              end else win_cnt <= win_cnt + 8'h01;
            end
          end
          WDT_OPEN: begin
            if (good_trig) begin
              wdt_st <= WDT_CLOSED;
              win_cnt <= 8'h00;
            end else if (osc_tick) win_cnt <= win_cnt + 8'h01;
          end
          default: wdt_st <= WDT_LEAD;
        endcase
      end
    end
  end

  // Dominant timeout on the transmit input
  wire dom_timeout = (dom_cnt >= CNT_W'(DOM_CYC));
  wire dom_sleep   = (dom_cnt >= CNT_W'(DOM_SL_CYC));
  always_ff @(posedge aclk) begin
    if (!aresetn) dom_cnt <= '0;
    else if (ce) begin
      if (tx_in || mode != MODE_NORMAL) dom_cnt <= '0;
      else if (!dom_sleep) dom_cnt <= dom_cnt + 1'b1;
    end
  end

  wire ign_rise  = ignition_wake_in && !ign_d;
  wire low_power = (mode == MODE_SILENT) || (mode == MODE_SLEEP);
  wire loc_wake  = low_power && (!local_wake_in_n || ign_rise);
  wire rem_wake  = low_power && bus_wake;
  wire go_sleep  = ctrl[CTRL_SLEEP_BIT] && (tx_in || dom_sleep);

  always_comb begin
    next_mode = mode;
    case (mode)
      MODE_FAILSAFE: if (ctrl_enable_pin && !in_reset) next_mode = MODE_NORMAL;
      MODE_NORMAL: begin
        if (!ctrl_enable_pin && go_sleep) next_mode = MODE_SLEEP;
        else if (!ctrl_enable_pin && ctrl[CTRL_SILENT_BIT]) next_mode = MODE_SILENT;
      end
      MODE_SILENT, MODE_SLEEP: begin
        if (loc_wake || rem_wake) next_mode = MODE_FAILSAFE;
        else if (ctrl_enable_pin) next_mode = MODE_NORMAL;
      end
      default: next_mode = MODE_FAILSAFE;
    endcase
    if (undervoltage || fail_now) next_mode = MODE_FAILSAFE;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode <= MODE_FAILSAFE;
      ign_d <= 1'b0;
      local_wake <= 1'b0;
      wake_seen <= 1'b0;
    end else if (ce) begin
      mode <= next_mode;
      ign_d <= ignition_wake_in;
      if (loc_wake || rem_wake) begin
        wake_seen <= 1'b1;
        local_wake <= loc_wake;
      end else if (ctrl_enable_pin) wake_seen <= 1'b0;
    end
  end

  // Outputs decoded from the mode and reset state
  wire xcvr_on = (mode == MODE_NORMAL) && !in_reset && !undervoltage;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_drive_dominant <= 1'b0;
      ctrl_rx_pin <= 1'b1;
      reset_out_n <= 1'b0;
      aux_supply_switch_out <= 1'b1;
      tx_out <= 1'b1;
      tx_oe_n <= 1'b1;
      status <= '0;
    end else if (ce) begin
      bus_drive_dominant <= xcvr_on && !tx_in && !dom_timeout;
      ctrl_rx_pin <= xcvr_on ? bus_level : 1'b1;
      reset_out_n <= !(in_reset || fail_now || undervoltage);
      aux_supply_switch_out <= (next_mode == MODE_NORMAL)
                               || (next_mode == MODE_FAILSAFE);
      // Low pull on transmit pin marks a local wake
      tx_out <= 1'b0;
      tx_oe_n <= !(wake_seen && local_wake && !ctrl_enable_pin);
      status <= '{local_wake: local_wake, wake_seen: wake_seen,
                  dom_timeout: dom_timeout, wdt_fail: wdt_fail, mode: mode};
    end
  end
  assign reset_oe_n = reset_out_n;

  a_early_trig_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && early_trig && !in_reset |=> !reset_out_n)
    else $error("closed window trigger gave no reset");
  a_missed_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && missed && !in_reset |=> !reset_out_n && in_reset)
    else $error("missed trigger gave no reset");
  a_wdt_off_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && low_power |=> wdt_st == WDT_LEAD && !in_reset)
    else $error("watchdog active in low power mode");
  a_wake_show: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && wake_seen && local_wake && !ctrl_enable_pin |=> !tx_oe_n)
    else $error("local wake not shown on transmit pin");
  a_xcvr_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && !xcvr_on |=> !bus_drive_dominant && ctrl_rx_pin)
    else $error("transceiver active outside normal");
  a_dom_release: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && dom_timeout |=> !bus_drive_dominant)
    else $error("dominant not released after timeout");
  a_tx_drive: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && xcvr_on && !tx_in && !dom_timeout |=> bus_drive_dominant)
    else $error("dominant not driven");
  sequence low_power_held;
    ce && low_power && $stable(mode) ##1 ce && $stable(mode);
  endsequence
  a_supply_off: assert property (@(posedge aclk) disable iff (!aresetn)
    low_power_held |-> !aux_supply_switch_out)
    else $error("supply switch on in low power");
  a_fail_safe: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && (undervoltage || fail_now) |=> mode == MODE_FAILSAFE)
    else $error("no fail-safe after fault");
  a_ign_edge: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && low_power && ign_d && ignition_wake_in && local_wake_in_n
    && !bus_wake && !ctrl_enable_pin && !undervoltage |=> $stable(mode))
    else $error("ignition level woke the device");
endmodule : lin_sbc_watchdog_mode_control
`default_nettype wire

/* mcu_partner.sv */
/*
  Controller model on the watchdog trigger line.
  Assumes a 200-cycle lead and 64-cycle windows after reset release.
*/
`default_nettype none
module mcu_partner (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic run,
  input  wire logic early,
  output logic      trig_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // Edge lands mid open window, leaving room for tick jitter
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt    <= 0;
      trig_n <= 1'h1;
    end else begin
      cnt    <= (cnt == 327) ? 232 : cnt + 1;
      trig_n <= !(run && (cnt inside {[232:239]} || early && cnt inside {[252:255]}));
    end
  end
endmodule : mcu_partner
`default_nettype wire

/* test_lin_sbc_watchdog_mode_control.sv */
/*
  Bench of the basis-chip control block: AXI4-Lite master, pin model,
  watchdog, transceiver, mode and wake scenarios.
  Assumes shortened counts and an oscillator period of 4 cycles.
*/
`default_nettype none
module test_lin_sbc_watchdog_mode_control
  import sbc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 0, aresetn = 0, en = 0, mtx = 1, mtx_en = 1, bus = 0;
  logic        lw_n = 1, ign = 0, bw = 0, uv = 0, wsel = 0, run = 1, early = 0, ce = 1;
  logic        awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic [7:0]  ad = '0;
  logic [3:0]  ws = 4'hf;
  logic [31:0] wd = '0;
  logic [15:0] seed = 16'hb006;
  wire logic   trig_n, tx_in, tx_out, tx_oe_n, rx, rst_n, aux, dom, roe_n;
  wire logic   awr, wr_r, bv, arr, rv;
  wire logic [1:0]  br, rr;
  wire logic [31:0] rdat;
  int          n_errors = 0, checked = 0, lows = 0, bad = 0;
  logic        prev;
  // Transmit pin: device pulls low, else controller or pull-up
  assign tx_in = !tx_oe_n ? tx_out : (mtx_en ? mtx : 1'h1);
  mcu_partner u_mcu (.aclk(aclk), .aresetn(aresetn), .run(run), .early(early),
    .trig_n(trig_n));
  lin_sbc_watchdog_mode_control #(.LEAD_CYC(200), .DOM_CYC(20), .DOM_SL_CYC(60)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .wdt_trigger_in_n(trig_n),
    .ctrl_enable_pin(en), .tx_in(tx_in), .tx_out(tx_out), .tx_oe_n(tx_oe_n),
    .ctrl_rx_pin(rx), .reset_out_n(rst_n), .reset_oe_n(roe_n), .aux_supply_switch_out(aux),
    .bus_drive_dominant(dom), .bus_level(bus), .local_wake_in_n(lw_n),
    .ignition_wake_in(ign), .bus_wake(bw), .undervoltage(uv), .watchdog_off_sel(wsel),
    .wdt_oscillator_set(16'h0004), .s_axi_awaddr(ad), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr_r), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_araddr(ad), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre));
  initial begin
    forever #5 aclk = ~aclk;
  end
  always @(negedge aclk) begin
    lows += (rst_n === 1'h0);
    if (prev === 1'h0 && rst_n === 1'h0 && (rx !== 1'h1 || dom !== 1'h0)) bad++;
    if (roe_n !== rst_n) bad++;
    prev = rst_n;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic at(input int n);
    repeat (n) @(posedge aclk);
  endtask : at
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tally_and_finish();
    if (n_errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic xfer(input bit w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic [1:0] r);
    bit at_ok, d_ok, fin;
    at_ok = 0;
    d_ok = !w;
    fin = 0;
    @(posedge aclk);
    ad <= a;
    wd <= d;
    awv <= w;
    wv <= w;
    arv <= !w;
    while (!(at_ok && d_ok)) begin
      @(posedge aclk);
      at_ok = at_ok | (w ? awr : arr);
      d_ok = d_ok | wr_r;
      awv <= w && !at_ok;
      arv <= !w && !at_ok;
      wv <= w && !d_ok;
    end
    bre <= w;
    rre <= !w;
    while (!fin) begin
      @(posedge aclk);
      fin = w ? bv : rv;
      q = rdat;
      r = w ? br : rr;
    end
    bre <= 1'h0;
    rre <= 1'h0;
  endtask : xfer
  // Bus held dominant so the receive gate shows
  task automatic expect_mode(input logic [3:0] m);
    logic [31:0] q;
    logic [1:0]  r;
    xfer(0, STATUS_OFFS, '0, q, r);
    @(negedge aclk);
    chk("mode", q[3:0], m);
    chk("aux", aux, m[0] | m[1]);
    chk("rx", rx, !m[1]);
    if (!m[1]) chk("dom", dom, 1'h0);
    @(posedge aclk);
  endtask : expect_mode
  initial begin
    logic [31:0] q;
    logic [1:0]  r, e;
    logic [1:0]  pq[$];
    at(5);
    aresetn <= 1'h1;
    expect_mode(MODE_FAILSAFE);
    xfer(0, OSC_OFFS, '0, q, r);
    chk("osc", q, 32'h0000_0004);
    en <= 1'h1;
    at(4);
    expect_mode(MODE_NORMAL);
    lows = 0;
    at(700);
    chk("wdt ok", lows, 0);
    early <= 1'h1;
    repeat (150) if (rst_n !== 1'h0) @(posedge aclk);
    chk("closed edge", rst_n, 1'h0);
    run <= 1'h0;
    early <= 1'h0;
    repeat (50) if (rst_n !== 1'h1) @(posedge aclk);
    lows = 0;
    at(190);
    chk("lead", lows, 0);
    at(110);
    chk("rst len", lows inside {[4 * WDT_RESET_OSC - 2:4 * WDT_RESET_OSC + 1]}, 1'h1);
    chk("xcvr in reset", bad, 0);
    wsel <= 1'h1;
    lows = 0;
    at(400);
    chk("wdt off", lows, 0);
    uv <= 1'h1;
    at(3);
    chk("uv reset", rst_n, 1'h0);
    expect_mode(MODE_FAILSAFE);
    uv <= 1'h0;
    at(30);
    expect_mode(MODE_NORMAL);
    for (int i = 0; i < 60; i++) begin
      seed = lfsr(seed);
      mtx <= seed[0] | seed[1];
      bus <= seed[2];
      pq.push_back({seed[0] | seed[1], seed[2]});
      @(negedge aclk);
      if (pq.size() == 2) begin
        e = pq.pop_front();
        chk("dom", dom, !e[1]);
        chk("rx", rx, e[0]);
      end
      @(posedge aclk);
    end
    ce <= 1'h0;
    mtx <= 1'h0;
    bus <= !bus;
    at(5);
    e = pq.pop_front();
    chk("frozen", {dom, rx}, {!e[1], e[0]});
    ce <= 1'h1;
    bus <= 1'h0;
    at(15);
    chk("dom held", dom, 1'h1);
    at(10);
    chk("dom timeout", dom, 1'h0);
    mtx <= 1'h1;
    xfer(1, 8'h0c, 32'h0000_0001, q, r);
    chk("bad wr", r, 2'h2);
    xfer(0, 8'h0c, '0, q, r);
    chk("bad rd", r, 2'h2);
    ws <= 4'h1;
    xfer(1, OSC_OFFS, 32'h0000_1203, q, r);
    xfer(0, OSC_OFFS, '0, q, r);
    chk("osc strobe", q, 32'h0000_0003);
    ws <= 4'hf;
    xfer(1, OSC_OFFS, 32'h0000_0004, q, r);
    for (int k = 0; k < 3; k++) begin
      xfer(1, CTRL_OFFS, (k == 1) ? 32'h0000_0002 : 32'h0000_0001, q, r);
      xfer(0, CTRL_OFFS, '0, q, r);
      chk("ctrl", q[1:0], (k == 1) ? 2'h2 : 2'h1);
      ign <= (k == 1);
      mtx <= (k != 0);
      at(70);
      en <= 1'h0;
      mtx_en <= (k == 0);
      at(4);
      expect_mode((k == 1) ? MODE_SILENT : MODE_SLEEP);
      mtx_en <= 1'h0;
      wsel <= 1'h0;
      lows = 0;
      at(300);
      chk("wdt asleep", lows, 0);
      wsel <= 1'h1;
      lw_n <= (k != 0);
      bw <= (k == 2);
      ign <= 1'h0;
      at(4);
      if (k == 1) expect_mode(MODE_SILENT);
      ign <= (k == 1);
      at(4);
      lw_n <= 1'h1;
      bw <= 1'h0;
      expect_mode(MODE_FAILSAFE);
      chk("wake src", tx_in, k == 2);
      en <= 1'h1;
      mtx_en <= 1'h1;
      mtx <= 1'h1;
      at(4);
      expect_mode(MODE_NORMAL);
    end
    chk("pins", bad, 0);
    tally_and_finish();
  end
  initial begin
    at(30000);
    n_errors++;
    tally_and_finish();
  end
endmodule : test_lin_sbc_watchdog_mode_control
`default_nettype wire
